/* File: hw/pfc_map.vh */
// constants for the parallel flash command controller: operation codes, addresses,
// command bytes and timing figures with their cycle counts at the reference clock.
// assumes a 250 MHz reference clock and an x16 asynchronous nor flash behind the pins.
//
// Functional notes
// - resume a suspended sector or block erase with one write of 30H, any address.
// - chip erase is six writes, the last 10H at 555H; erases to ones.
// - host presents the address being programmed or erased on status reads.
// - reset pin low for the minimum pulse aborts work, returns to array read.
// - host waits reset recovery time after reset release before reading.
// - host reissues a program or erase that a hardware reset interrupted; the controller never reissues one.
// - unlock always on: program needs three-cycle preamble, erase six cycles.
// - on doubtful status, read twice more; accept completion only if both agree.
// - one write of B0H suspends an erase; read mode within about 20 us.
`ifndef PFC_MAP_VH
`define PFC_MAP_VH

// user operation codes
`define PFC_OP_READ 3'h0
`define PFC_OP_PROG 3'h1
`define PFC_OP_SECT 3'h2
`define PFC_OP_BLK 3'h3
`define PFC_OP_CHIP 3'h4
`define PFC_OP_SUSP 3'h5
`define PFC_OP_RESUME 3'h6
`define PFC_OP_HWRST 3'h7

// unlock addresses and bytes, customary standard interface values
`define PFC_UNL_ADDR1 20'h0_0555
`define PFC_UNL_ADDR2 20'h0_02AA
`define PFC_UNL_DATA1 16'h0_0AA
`define PFC_UNL_DATA2 16'h0_055
`define PFC_CMD_PROG 16'h0_0A0
`define PFC_CMD_ERASE 16'h0_080
`define PFC_CMD_SECT 16'h0_050
`define PFC_CMD_BLK 16'h0_030
`define PFC_CMD_CHIP 16'h0_010
`define PFC_CMD_SUSP 16'h0_0B0
`define PFC_CMD_RESUME 16'h0_030

// status bit positions on the data bus
`define PFC_BIT_POLL 7
`define PFC_BIT_TOG1 6
`define PFC_BIT_TOG2 2

// timing figures in ns and derived cycle counts
`define PFC_CLK_NS 4
`define PFC_WE_LOW_NS 5
`define PFC_WE_LOW_CYC ((`PFC_WE_LOW_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_WE_HIGH_NS 20
`define PFC_WE_HIGH_CYC ((`PFC_WE_HIGH_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_RD_NS 100
`define PFC_RD_CYC ((`PFC_RD_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_RD_GAP_CYC 2
`define PFC_SYNC_CYC 2
`define PFC_SETTLE_NS 1000
`define PFC_SETTLE_CYC ((`PFC_SETTLE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_SUSP_NS 20000
`define PFC_SUSP_CYC ((`PFC_SUSP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_RST_PULSE_NS 500
`define PFC_RST_PULSE_CYC ((`PFC_RST_PULSE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_RST_REC_NS 100
`define PFC_RST_REC_CYC ((`PFC_RST_REC_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)

`endif

/* File: hw/pfc_ctrl.v */
// host-side controller for an x16 asynchronous nor flash: issues unlocked
// program, erase, suspend, resume, plain reads and hardware reset pulses.
// assumes one 250 MHz clock, a flash wired to the pin ports, and a board-level
// pull-up plus tristate resolution done outside this module.
`timescale 1ns/1ps
`include "pfc_map.vh"

module pfc_ctrl #(
    parameter [15:0] SUSP_CYC = `PFC_SUSP_CYC,
    parameter [15:0] RST_PULSE_CYC = `PFC_RST_PULSE_CYC,
    parameter [15:0] RST_REC_CYC = `PFC_RST_REC_CYC,
    parameter [15:0] SETTLE_CYC = `PFC_SETTLE_CYC
) (
    input wire i_ref_clk,
    input wire i_reset,
    input wire i_req_valid,
    input wire [2:0] i_req_op,
    input wire [19:0] i_req_addr,
    input wire [15:0] i_req_wdata,
    input wire i_boot_protect,
    output wire o_req_ready,
    output reg o_rsp_valid,
    output reg [15:0] o_rsp_rdata,
    output reg o_rsp_aborted,
    output wire o_dev_busy,
    output reg [19:0] o_fl_addr,
    output reg o_fl_ce_n,
    output reg o_fl_oe_n,
    output reg o_fl_we_n,
    output reg o_fl_wp_n,
    output reg o_fl_rst_n,
    output reg [15:0] o_fl_dq,
    output reg o_fl_dq_oe_n,
    input wire [15:0] i_fl_dq,
    input wire i_op_done_out
);

// ----------------------------------------------------------------------------
// states, modes and timing counts
// ----------------------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_WLOW = 3'h1;
localparam [2:0] ST_WHIGH = 3'h2;
localparam [2:0] ST_RLOW = 3'h3;
localparam [2:0] ST_RHIGH = 3'h4;
localparam [2:0] ST_WAIT = 3'h5;
localparam [2:0] ST_RST = 3'h6;

localparam [2:0] M_DATA = 3'h0;
localparam [2:0] M_POLL = 3'h1;
localparam [2:0] M_SETTLE = 3'h2;
localparam [2:0] M_SUSP = 3'h3;
localparam [2:0] M_RST = 3'h4;

localparam [15:0] WE_LOW_CYC = `PFC_WE_LOW_CYC;
localparam [15:0] WE_HIGH_CYC = `PFC_WE_HIGH_CYC;
localparam [15:0] RD_LOW_CYC = `PFC_RD_CYC + `PFC_SYNC_CYC;
localparam [15:0] RD_GAP_CYC = `PFC_RD_GAP_CYC;

reg [2:0] state;
reg [2:0] mode;
reg [15:0] cnt;
reg [2:0] step;
reg [2:0] op;
reg [19:0] op_addr;
reg [15:0] op_wdata;
reg running;
reg have_prev;
reg prev_tog;
reg [1:0] agree;
reg [15:0] dq_s1;
reg [15:0] dq_s2;
reg done_s1;
reg done_s2;

// ----------------------------------------------------------------------------
// command script: address and data of each write cycle
// ----------------------------------------------------------------------------
// unlock preamble always leads program and erase; erase repeats it once
function [35:0] pfc_seq;
    input [2:0] f_op;
    input [2:0] f_idx;
    input [19:0] f_addr;
    input [15:0] f_wdata;
    reg [15:0] erase_cmd;
    reg [19:0] erase_addr;
    begin
        erase_cmd = (f_op == `PFC_OP_SECT) ? `PFC_CMD_SECT :
                    (f_op == `PFC_OP_BLK) ? `PFC_CMD_BLK : `PFC_CMD_CHIP;
        erase_addr = (f_op == `PFC_OP_CHIP) ? `PFC_UNL_ADDR1 : f_addr;
        case (f_idx)
            3'h0: pfc_seq = {`PFC_UNL_ADDR1, `PFC_UNL_DATA1};
            3'h1: pfc_seq = {`PFC_UNL_ADDR2, `PFC_UNL_DATA2};
            3'h2: pfc_seq = (f_op == `PFC_OP_PROG) ? {`PFC_UNL_ADDR1, `PFC_CMD_PROG}
                                                   : {`PFC_UNL_ADDR1, `PFC_CMD_ERASE};
            3'h3: pfc_seq = (f_op == `PFC_OP_PROG) ? {f_addr, f_wdata}
                                                   : {`PFC_UNL_ADDR1, `PFC_UNL_DATA1};
            3'h4: pfc_seq = {`PFC_UNL_ADDR2, `PFC_UNL_DATA2};
            default: pfc_seq = {erase_addr, erase_cmd};
        endcase
    end
endfunction

// index of the last write cycle of each operation
function [2:0] pfc_last;
    input [2:0] f_op;
    begin
        case (f_op)
            `PFC_OP_PROG: pfc_last = 3'h3;
            `PFC_OP_SECT, `PFC_OP_BLK, `PFC_OP_CHIP: pfc_last = 3'h5;
            default: pfc_last = 3'h0;
        endcase
    end
endfunction

wire [35:0] seq_word = pfc_seq(op, step, op_addr, op_wdata);
wire [35:0] susp_word = {op_addr, (op == `PFC_OP_SUSP) ? `PFC_CMD_SUSP : `PFC_CMD_RESUME};
wire [35:0] wr_word = (op == `PFC_OP_SUSP || op == `PFC_OP_RESUME) ? susp_word : seq_word;
wire [35:0] first_word = (i_req_op == `PFC_OP_SUSP) ? {i_req_addr, `PFC_CMD_SUSP} :
                         (i_req_op == `PFC_OP_RESUME) ? {i_req_addr, `PFC_CMD_RESUME} :
                         {`PFC_UNL_ADDR1, `PFC_UNL_DATA1};
wire [35:0] next_word = pfc_seq(op, step + 3'h1, op_addr, op_wdata);

// ----------------------------------------------------------------------------
// pin input synchronisers
// ----------------------------------------------------------------------------
// data bus and the open-drain ready pin come from outside the clock domain
always @(posedge i_ref_clk)
begin
    dq_s1 <= i_fl_dq;
    dq_s2 <= dq_s1;
    done_s1 <= i_op_done_out;
    done_s2 <= done_s1;
end

// low on the pulled-up pin means the flash is still working
assign o_dev_busy = ~done_s2;
assign o_req_ready = (state == ST_IDLE);

// ----------------------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------------------
// pins are registered so no strobe glitches shorter than a clock reach the part
always @(posedge i_ref_clk)
begin
    if (i_reset)
    begin
        state <= ST_IDLE;
        mode <= M_DATA;
        cnt <= 16'h0000;
        step <= 3'h0;
        op <= `PFC_OP_READ;
        op_addr <= 20'h0_0000;
        op_wdata <= 16'h0000;
        running <= 1'b0;
        have_prev <= 1'b0;
        prev_tog <= 1'b0;
        agree <= 2'h0;
        o_rsp_valid <= 1'b0;
        o_rsp_rdata <= 16'h0000;
        o_rsp_aborted <= 1'b0;
        o_fl_addr <= 20'h0_0000;
        o_fl_ce_n <= 1'b1;
        o_fl_oe_n <= 1'b1;
        o_fl_we_n <= 1'b1;
        o_fl_wp_n <= 1'b1;
        o_fl_rst_n <= 1'b1;
        o_fl_dq <= 16'h0000;
        o_fl_dq_oe_n <= 1'b1;
    end
    else
    begin
        o_rsp_valid <= 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (i_req_valid)
                begin
                    op <= i_req_op;
                    op_addr <= i_req_addr;
                    op_wdata <= i_req_wdata;
                    step <= 3'h0;
                    o_rsp_aborted <= 1'b0;
                    // held from here to the end so the part sees it static
                    o_fl_wp_n <= ~i_boot_protect;
                    if (i_req_op == `PFC_OP_READ)
                    begin
                        mode <= M_DATA;
                        state <= ST_RLOW;
                        cnt <= RD_LOW_CYC - 16'h0001;
                        o_fl_addr <= i_req_addr;
                        o_fl_ce_n <= 1'b0;
                        o_fl_oe_n <= 1'b0;
                    end
                    else if (i_req_op == `PFC_OP_HWRST)
                    begin
                        state <= ST_RST;
                        cnt <= RST_PULSE_CYC - 16'h0001;
                        o_fl_rst_n <= 1'b0;
                        // tell the user the interrupted job must be redone
                        o_rsp_aborted <= running;
                        running <= 1'b0;
                    end
                    else
                    begin
                        state <= ST_WLOW;
                        cnt <= WE_LOW_CYC - 16'h0001;
                        o_fl_addr <= first_word[35:16];
                        o_fl_dq <= first_word[15:0];
                        o_fl_dq_oe_n <= 1'b0;
                        o_fl_ce_n <= 1'b0;
                        o_fl_we_n <= 1'b0;
                    end
                end
            end
            ST_WLOW:
            begin
                // low time never shorter than the glitch filter of the part
                if (cnt == 16'h0000)
                begin
                    state <= ST_WHIGH;
                    cnt <= WE_HIGH_CYC - 16'h0001;
                    o_fl_we_n <= 1'b1;
                    o_fl_ce_n <= 1'b1;
                end
                else
                    cnt <= cnt - 16'h0001;
            end
            ST_WHIGH:
            begin
                if (cnt != 16'h0000)
                    cnt <= cnt - 16'h0001;
                else if (step != pfc_last(op))
                begin
                    step <= step + 3'h1;
                    state <= ST_WLOW;
                    cnt <= WE_LOW_CYC - 16'h0001;
                    o_fl_addr <= next_word[35:16];
                    o_fl_dq <= next_word[15:0];
                    o_fl_ce_n <= 1'b0;
                    o_fl_we_n <= 1'b0;
                end
                else
                begin
                    o_fl_dq_oe_n <= 1'b1;
                    case (op)
                        `PFC_OP_SUSP:
                        begin
                            mode <= M_SUSP;
                            state <= ST_WAIT;
                            cnt <= SUSP_CYC - 16'h0001;
                        end
                        `PFC_OP_RESUME:
                        begin
                            state <= ST_IDLE;
                            o_rsp_valid <= 1'b1;
                        end
                        default:
                        begin
                            // last strobe is up: status is valid from here
                            running <= 1'b1;
                            mode <= M_POLL;
                            have_prev <= 1'b0;
                            agree <= 2'h0;
                            state <= ST_RLOW;
                            cnt <= RD_LOW_CYC - 16'h0001;
                            o_fl_addr <= op_addr;
                            o_fl_ce_n <= 1'b0;
                            o_fl_oe_n <= 1'b0;
                        end
                    endcase
                end
            end
            ST_RLOW:
            begin
                if (cnt == 16'h0000)
                begin
                    o_rsp_rdata <= dq_s2;
                    state <= ST_RHIGH;
                    cnt <= RD_GAP_CYC - 16'h0001;
                    o_fl_ce_n <= 1'b1;
                    o_fl_oe_n <= 1'b1;
                end
                else
                    cnt <= cnt - 16'h0001;
            end
            ST_RHIGH:
            begin
                if (cnt != 16'h0000)
                    cnt <= cnt - 16'h0001;
                else if (mode == M_DATA)
                begin
                    state <= ST_IDLE;
                    o_rsp_valid <= 1'b1;
                end
                else
                begin
                    // a flip means still busy; two further equal reads confirm the end
                    prev_tog <= o_rsp_rdata[`PFC_BIT_TOG1];
                    have_prev <= 1'b1;
                    if (have_prev && o_rsp_rdata[`PFC_BIT_TOG1] == prev_tog && agree == 2'h1)
                    begin
                        running <= 1'b0;
                        mode <= M_SETTLE;
                        state <= ST_WAIT;
                        cnt <= SETTLE_CYC - 16'h0001;
                    end
                    else
                    begin
                        if (have_prev && o_rsp_rdata[`PFC_BIT_TOG1] == prev_tog)
                            agree <= agree + 2'h1;
                        else
                            agree <= 2'h0;
                        state <= ST_RLOW;
                        cnt <= RD_LOW_CYC - 16'h0001;
                        o_fl_ce_n <= 1'b0;
                        o_fl_oe_n <= 1'b0;
                    end
                end
            end
            ST_WAIT:
            begin
                if (cnt != 16'h0000)
                    cnt <= cnt - 16'h0001;
                else if (mode == M_SETTLE)
                begin
                    // final read returns the whole settled word
                    mode <= M_DATA;
                    state <= ST_RLOW;
                    cnt <= RD_LOW_CYC - 16'h0001;
                    o_fl_ce_n <= 1'b0;
                    o_fl_oe_n <= 1'b0;
                end
                else
                begin
                    state <= ST_IDLE;
                    o_rsp_valid <= 1'b1;
                end
            end
            ST_RST:
            begin
                if (cnt == 16'h0000)
                begin
                    o_fl_rst_n <= 1'b1;
                    mode <= M_RST;
                    state <= ST_WAIT;
                    cnt <= RST_REC_CYC - 16'h0001;
                end
                else
                    cnt <= cnt - 16'h0001;
            end
            default:
                state <= ST_IDLE;
        endcase
    end
end

endmodule // pfc_ctrl

/* File: tb/pfc_ctrl_sva.sv */
// checker for the flash command controller: strobe shapes, reset pin, handshake.
// assumes reset-pin counts equal those of the bound controller instance.
`timescale 1ns/1ps
`include "pfc_map.vh"

module pfc_ctrl_sva #(
    parameter [15:0] RST_PULSE_CYC = 16'h007d,
    parameter [15:0] RST_REC_CYC = 16'h0019
) (
    input wire i_ref_clk,
    input wire i_reset,
    input wire i_req_valid,
    input wire [2:0] i_req_op,
    input wire i_boot_protect,
    input wire o_req_ready,
    input wire o_dev_busy,
    input wire [19:0] o_fl_addr,
    input wire o_fl_ce_n,
    input wire o_fl_oe_n,
    input wire o_fl_we_n,
    input wire o_fl_wp_n,
    input wire o_fl_rst_n,
    input wire [15:0] o_fl_dq,
    input wire o_fl_dq_oe_n,
    input wire i_op_done_out
);
    logic [15:0] rst_low;
    logic [15:0] rec_cnt;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    // reset pin low length, and cycles since release (saturates, so idle never trips)
    always @(posedge i_ref_clk)
    begin
        rst_low <= (i_reset || o_fl_rst_n) ? 16'h0000 : rst_low + 16'h0001;
        rec_cnt <= i_reset ? 16'hffff : !o_fl_rst_n ? 16'h0000 :
            (rec_cnt == 16'hffff) ? rec_cnt : rec_cnt + 16'h0001;
    end

    // --------------------------------------------------------------------
    // pin checks
    // --------------------------------------------------------------------
    AST_WE_PULSE: assert property ($fell(o_fl_we_n) |=> !o_fl_we_n ##1 o_fl_we_n)
        else $error("write strobe low time is not two cycles");
    AST_WR_INHIBIT: assert property (!o_fl_we_n |-> !o_fl_ce_n && o_fl_oe_n && !o_fl_dq_oe_n)
        else $error("write strobe low without select or with output gate low");
    AST_LATCH_HOLD: assert property (!o_fl_we_n && $past(!o_fl_we_n) |->
        $stable(o_fl_addr) && $stable(o_fl_dq))
        else $error("address or data moved inside a write pulse");
    AST_WP_FOLLOW: assert property (i_req_valid && o_req_ready |=>
        o_fl_wp_n == !$past(i_boot_protect))
        else $error("protect pin does not follow the request");
    AST_RST_PULSE: assert property ($rose(o_fl_rst_n) |-> rst_low >= RST_PULSE_CYC)
        else $error("reset pin pulse too short");
    AST_RST_RECOVER: assert property ($fell(o_fl_ce_n) |-> rec_cnt >= RST_REC_CYC)
        else $error("flash selected inside reset recovery");
    AST_RESUME_CMD: assert property (i_req_valid && o_req_ready && i_req_op == `PFC_OP_RESUME
        |-> ##[1:3] ($fell(o_fl_we_n) && o_fl_dq == `PFC_CMD_RESUME))
        else $error("resume request did not write the resume code");
    AST_BUSY_SYNC: assert property (!i_op_done_out ##1 !i_op_done_out |=> o_dev_busy)
        else $error("busy flag missed a low op-done pin");
    AST_TAKE_BUSY: assert property (i_req_valid && o_req_ready |=> !o_req_ready)
        else $error("new request accepted while an operation runs");
endmodule // pfc_ctrl_sva

bind pfc_ctrl pfc_ctrl_sva #(.RST_PULSE_CYC(RST_PULSE_CYC), .RST_REC_CYC(RST_REC_CYC))
    u_pfc_ctrl_sva (.i_ref_clk, .i_reset, .i_req_valid, .i_req_op, .i_boot_protect,
    .o_req_ready, .o_dev_busy, .o_fl_addr, .o_fl_ce_n, .o_fl_oe_n, .o_fl_we_n,
    .o_fl_wp_n, .o_fl_rst_n, .o_fl_dq, .o_fl_dq_oe_n, .i_op_done_out);

/* File: tb/pfc_flash_model.sv */
// behavioural x16 nor flash: unlock decoder, status bits, op-done pin, reset pin.
// assumes controller pins wired straight in; the bench resolves the data bus.
`timescale 1ns/1ps
`include "pfc_map.vh"

module pfc_flash_model #(
    parameter realtime T_PROG = 2000.0,
    parameter realtime T_ERASE = 4000.0,
    parameter realtime RST_LOW_MIN = 12.0,
    parameter realtime RST_REC_MIN = 16.0,
    parameter [6:0] BOOT_TOP = 7'h00
) (
    input wire [19:0] i_addr,
    input wire i_ce_n,
    input wire i_oe_n,
    input wire i_we_n,
    input wire i_wp_n,
    input wire i_rst_n,
    input wire [15:0] i_dq,
    output logic [15:0] o_dq = 16'h5a5a,
    output wire o_busy_low
);
    logic [15:0] mem [int];
    logic [19:0] lat_a = 20'h0_0000, op_a = 20'h0_0000;
    logic [15:0] op_d = 16'h0000;
    logic busy = 1'b0, susp = 1'b0, tog = 1'b0;
    int step = 0, kind = 0, n_susp = 0, n_resume = 0, n_reset = 0;
    realtime t_fall = 0.0, t_done = 0.0, t_fin = -1.0e9, t_rec = -1.0e9, t_rst = 0.0;
    wire wr_low = !i_ce_n && !i_we_n && i_oe_n;

    assign o_busy_low = busy && !susp;

    function automatic logic [15:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction

    // --------------------------------------------------------------------
    // command decoder
    // --------------------------------------------------------------------
    // refused commands never raise busy, so the host sees plain array data
    task automatic start(input logic [19:0] a, input logic [15:0] d, input int k);
        step = 0;
        if (k == 4 || (!i_wp_n && (k == 3 || a[19:13] == BOOT_TOP)))
            return;
        op_a = a;
        op_d = d;
        kind = k;
        busy = 1'b1;
        t_done = $realtime + ((k == 0) ? T_PROG : T_ERASE);
    endtask

    task automatic wr_cmd(input logic [19:0] a, input logic [15:0] d);
        n_susp += (step == 0 && d == `PFC_CMD_SUSP);
        n_resume += (step == 0 && d == `PFC_CMD_RESUME);
        if (busy && !susp && (kind == 1 || kind == 2) && d == `PFC_CMD_SUSP)
        begin
            susp = 1'b1;
            t_done = t_done - $realtime;
        end
        else if (susp && d == `PFC_CMD_RESUME)
        begin
            susp = 1'b0;
            t_done = t_done + $realtime;
        end
        else if (!busy)
            case (step)
                0: step = (a == `PFC_UNL_ADDR1 && d == `PFC_UNL_DATA1) ? 1 : 0;
                1, 4: step = (a == `PFC_UNL_ADDR2 && d == `PFC_UNL_DATA2) ? step + 1 : 0;
                2: step = (a != `PFC_UNL_ADDR1) ? 0 : (d == `PFC_CMD_PROG) ? 9 :
                    (d == `PFC_CMD_ERASE) ? 3 : 0;
                3: step = (a == `PFC_UNL_ADDR1 && d == `PFC_UNL_DATA1) ? 4 : 0;
                5: start(a, d, (d == `PFC_CMD_SECT) ? 1 : (d == `PFC_CMD_BLK) ? 2 :
                    (d == `PFC_CMD_CHIP && a == `PFC_UNL_ADDR1) ? 3 : 4);
                9: start(a, d, 0);
                default: step = 0;
            endcase
    endtask

    // address at the later falling edge of the strobes, data at the earlier rise
    always @(posedge wr_low)
    begin
        t_fall = $realtime;
        lat_a = i_addr;
    end

    // glitches and inhibited cycles never reach the decoder
    always @(negedge wr_low)
        if ($realtime - t_fall >= 5.0 && i_rst_n && i_oe_n)
            wr_cmd(lat_a, i_dq);

    // --------------------------------------------------------------------
    // engine, status reads, reset pin
    // --------------------------------------------------------------------
    task automatic finish_op();
        logic [19:0] k;
        if (kind == 0)
            mem[op_a] = rd(op_a) & op_d;
        foreach (mem[i])
        begin
            k = i;
            if (kind == 3 || (kind == 1 && k[19:11] == op_a[19:11]) ||
                (kind == 2 && k[19:15] == op_a[19:15]))
                mem[i] = 16'hffff;
        end
        busy = 1'b0;
        t_fin = $realtime;
    endtask

    always #1
        if (busy && !susp && $realtime >= t_done)
            finish_op();

    // upper byte is garbage shortly after completion or reset release
    always @(negedge i_oe_n)
    begin
        o_dq = rd(i_addr);
        if (!i_ce_n && busy && !susp)
        begin
            tog = ~tog;
            o_dq[7] = (kind == 0) ? ~op_d[7] : 1'b0;
            o_dq[6] = tog;
            o_dq[2] = (kind == 0) ? o_dq[2] : tog;
        end
        else if ($realtime - t_fin < 1000.0 || $realtime - t_rec < RST_REC_MIN)
            o_dq[15:8] = ~o_dq[15:8];
    end

    // a released bus must not look like the last word
    always @(posedge i_oe_n)
        o_dq = ~o_dq;

    always @(negedge i_rst_n)
        t_rst = $realtime;

    always @(posedge i_rst_n)
        if ($realtime - t_rst >= RST_LOW_MIN)
        begin
            busy = 1'b0;
            susp = 1'b0;
            step = 0;
            n_reset++;
            t_rec = $realtime;
        end
endmodule // pfc_flash_model

/* File: tb/tb_pfc_ctrl.sv */
// self-checking bench: controller against the behavioural flash model.
// assumes the controller, checker and flash model are compiled before it.
`timescale 1ns/1ps
`include "pfc_map.vh"

module tb_pfc_ctrl;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_req_valid = 1'b0, i_boot_protect = 1'b0;
    logic [2:0] i_req_op = 3'h0;
    logic [19:0] i_req_addr = 20'h0_0000;
    logic [15:0] i_req_wdata = 16'h0000;
    wire o_req_ready, o_rsp_valid, o_rsp_aborted, o_dev_busy, busy_low;
    wire o_fl_ce_n, o_fl_oe_n, o_fl_we_n, o_fl_wp_n, o_fl_rst_n, o_fl_dq_oe_n;
    wire [15:0] o_rsp_rdata, o_fl_dq, dev_dq;
    wire [19:0] o_fl_addr;
    int n_mismatch = 0, comparisons = 0, n_busy = 0;

    // busy flag must have been seen high while the model was working
    always @(posedge i_ref_clk)
        if (o_dev_busy === 1'b1)
            n_busy++;

    always #2 i_ref_clk = ~i_ref_clk;

    // open-drain op-done line idles high through its pull-up
    wire i_op_done_out = busy_low ? 1'b0 : 1'b1;
    wire [15:0] i_fl_dq = o_fl_dq_oe_n ? dev_dq : o_fl_dq;

    pfc_ctrl #(.SUSP_CYC(16'h0014), .RST_PULSE_CYC(16'h0004), .RST_REC_CYC(16'h0004),
        .SETTLE_CYC(16'h00fa)) u_pfc_ctrl (.i_ref_clk, .i_reset, .i_req_valid, .i_req_op,
        .i_req_addr, .i_req_wdata, .i_boot_protect, .o_req_ready, .o_rsp_valid, .o_rsp_rdata,
        .o_rsp_aborted, .o_dev_busy, .o_fl_addr, .o_fl_ce_n, .o_fl_oe_n, .o_fl_we_n,
        .o_fl_wp_n, .o_fl_rst_n, .o_fl_dq, .o_fl_dq_oe_n, .i_fl_dq, .i_op_done_out);

    pfc_flash_model u_pfc_flash_model (.i_addr(o_fl_addr), .i_ce_n(o_fl_ce_n),
        .i_oe_n(o_fl_oe_n), .i_we_n(o_fl_we_n), .i_wp_n(o_fl_wp_n), .i_rst_n(o_fl_rst_n),
        .i_dq(o_fl_dq), .o_dq(dev_dq), .o_busy_low(busy_low));

    // --------------------------------------------------------------------
    // access tasks
    // --------------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // values read at the edge are the settled ones from the cycle before it
    task automatic req(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req_op <= op;
        i_req_addr <= a;
        i_req_wdata <= d;
        do @(posedge i_ref_clk); while (o_req_ready !== 1'b1);
        i_req_valid <= 1'b0;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (o_rsp_valid !== 1'b1 && n < 50000);
        // a request that never answers is a failure, not a silent skip
        if (n >= 50000)
            n_mismatch++;
    endtask

    task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp);
        req(`PFC_OP_READ, a, 16'h0000);
        chk(o_rsp_rdata, exp);
    endtask

    // a hang counts as a failure and ends through the same verdict
    initial
    begin
        #200000;
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        chk({12'h000, o_req_ready, o_fl_ce_n, o_fl_we_n, o_fl_rst_n}, 16'h000f);
        req(`PFC_OP_PROG, 20'h1_2345, 16'ha5c3);
        chk(o_rsp_rdata, 16'ha5c3);
        rd_chk(20'h1_2345, 16'ha5c3);
        i_boot_protect <= 1'b1;
        req(`PFC_OP_PROG, 20'h0_0010, 16'h0000);
        chk(o_rsp_rdata, 16'hffff);
        i_boot_protect <= 1'b0;
        req(`PFC_OP_PROG, 20'h0_0010, 16'h1234);
        rd_chk(20'h0_0010, 16'h1234);
        req(`PFC_OP_SECT, 20'h1_2345, 16'h0000);
        chk(o_rsp_rdata, 16'hffff);
        rd_chk(20'h1_2000, 16'hffff);
        rd_chk(20'h0_0010, 16'h1234);
        i_boot_protect <= 1'b1;
        req(`PFC_OP_CHIP, 20'h0_0000, 16'h0000);
        rd_chk(20'h0_0010, 16'h1234);
        i_boot_protect <= 1'b0;
        req(`PFC_OP_CHIP, 20'h0_0000, 16'h0000);
        rd_chk(20'h0_0010, 16'hffff);
        req(`PFC_OP_PROG, 20'h4_0000, 16'h0f0f);
        req(`PFC_OP_BLK, 20'h4_1234, 16'h0000);
        rd_chk(20'h4_0000, 16'hffff);
        req(`PFC_OP_SUSP, 20'h3_0000, 16'h0000);
        req(`PFC_OP_RESUME, 20'h5_5555, 16'h0000);
        chk(16'(u_pfc_flash_model.n_susp), 16'h0001);
        chk(16'(u_pfc_flash_model.n_resume), 16'h0001);
        chk(16'(n_busy != 0), 16'h0001);
        req(`PFC_OP_HWRST, 20'h0_0000, 16'h0000);
        chk(16'(u_pfc_flash_model.n_reset), 16'h0001);
        chk({15'h0000, o_rsp_aborted}, 16'h0000);
        rd_chk(20'h4_0000, 16'hffff);
        print_verdict();
    end
endmodule // tb_pfc_ctrl
